// ### logic/iaw_defs.svh
`ifndef IAW_DEFS_SVH
`define IAW_DEFS_SVH

// ****************************************************************
// Source slots, in fixed priority order (slot 0 is served first)
// ****************************************************************
`define IAW_NUM_SRC      12
`define IAW_SRC_EXT_A    0
`define IAW_SRC_EXT_B    1
`define IAW_SRC_CNTR_A   2
`define IAW_SRC_CNTR_B   3
`define IAW_SRC_TIMER_X  4
`define IAW_SRC_TIMER_Y  5
`define IAW_SRC_PERIPH   4

// ****************************************************************
// Processor status bits, vectors and reset values
// ****************************************************************
`define IAW_PS_I_BIT     2
`define IAW_PS_B_BIT     4
`define IAW_BRK_PC_STEP  16'h0002
`define IAW_VEC_BRK      4'hC
`define IAW_RST_DISABLE  1'b1

// ****************************************************************
// Sources that may end stop mode, unconditionally or with the serial clock
// ****************************************************************
`define IAW_STOP_WAKE_FIXED  12'h00F
`define IAW_STOP_WAKE_SERIAL 12'h700

`endif

// ### logic/iaw_pkg.sv
`default_nettype none

package iaw_pkg;

  // Acceptance and return sequencer
  typedef enum logic [3:0] {
    SQ_IDLE     = 4'b0000,
    SQ_POST     = 4'b0001,
    SQ_PUSH_PCH = 4'b0010,
    SQ_PUSH_PCL = 4'b0011,
    SQ_PUSH_PS  = 4'b0100,
    SQ_VEC_LO   = 4'b0101,
    SQ_VEC_HI   = 4'b0110,
    SQ_POP_PS   = 4'b0111,
    SQ_POP_PCL  = 4'b1000,
    SQ_POP_PCH  = 4'b1001
  } seq_state_t;

  // Low-power state of the core
  typedef enum logic [1:0] {
    LP_RUN  = 2'b00,
    LP_WAIT = 2'b01,
    LP_STOP = 2'b10
  } lp_mode_t;

  // Processor context that is saved and restored
  typedef struct packed {
    logic [15:0] pc;
    logic [7:0]  ps;
  } cpu_ctx_t;

  // Vector fetch request towards the core
  typedef struct packed {
    logic       fetch;
    logic       high_byte;
    logic [3:0] index;
  } vec_req_t;

endpackage : iaw_pkg

`default_nettype wire

// ### logic/interrupt_accept_and_wakeup_control.sv
// Function
// - Accept at instruction end, then post-process, push, fetch vector.
// - An enabled request in wait mode, or from a stop wake source in stop mode, returns the core to run.
// - Pins, key-on end stop and wait; timers 1,2, converter wait only.
// - Timer X and Y end stop only in event count mode.
// - Serial and arbitration end stop only with external or divided clock.
// - Accept a source only with request 1, enable 1 and disable flag 0.
// - Priority among sources is fixed by slot order in hardware.
// - Source event sets its request bit; acceptance clears it.
// - Software may clear request bits but never set them.
// - Enable bit 0 blocks a source, 1 allows it.
// - Disable flag 1 blocks all sources except the break.
// - Branching into a service routine sets the disable flag.
// - Polarity change may set the request; software disables around it.
// - Edge detection stays live while pins serve as port inputs.
// - Key-on wakeup is ignored outside stop and wait modes.
// - The break pushes program counter plus two.
// - Break with flag set vectors to highest pending enabled source.
// - Push PC high, PC low, status; return pops in reverse order.
// - Break sets the break flag and is always accepted.

`timescale 1ns/1ps
`default_nettype none

`include "iaw_defs.svh"

module interrupt_accept_and_wakeup_control
  import iaw_pkg::*;
(
  // Clock and reset
  input  wire logic                    i_clk,
  input  wire logic                    i_rst_n,
  // Pins, asynchronous to the core clock
  input  wire logic                    i_external_edge_pin_a,
  input  wire logic                    i_external_edge_pin_b,
  input  wire logic                    i_counter_pin_a,
  input  wire logic                    i_counter_pin_b,
  input  wire logic [7:0]              i_keyscan_port,
  // Configuration from the core's control registers
  input  wire logic [3:0]              i_edge_pol,
  input  wire logic                    i_keyon_sel,
  input  wire logic [`IAW_NUM_SRC-1:0] i_enable,
  input  wire logic                    i_timer_x_event_mode,
  input  wire logic                    i_timer_y_event_mode,
  input  wire logic                    i_serial_ext_clk,
  // Peripheral request pulses, same clock
  input  wire logic [7:0]              i_periph_event,
  // Software access to the request bits
  input  wire logic                    i_req_wr,
  input  wire logic [`IAW_NUM_SRC-1:0] i_req_wr_data,
  output logic [`IAW_NUM_SRC-1:0]      o_req_bits,
  // Core sequencer handshake
  input  wire logic                    i_instr_done,
  input  wire logic                    i_brk,
  input  wire logic                    i_rti,
  input  wire logic                    i_sei,
  input  wire logic                    i_cli,
  input  wire logic                    i_stop_enter,
  input  wire logic                    i_wait_enter,
  input  wire cpu_ctx_t                i_ctx,
  input  wire logic [7:0]              i_stack_rdata,
  output logic                         o_busy,
  output logic                         o_stack_push,
  output logic                         o_stack_pop,
  output logic [7:0]                   o_stack_wdata,
  output vec_req_t                     o_vec,
  output logic                         o_branch,
  output logic                         o_restore_valid,
  output cpu_ctx_t                     o_restore_ctx,
  // Status
  output logic                         o_int_disable,
  output lp_mode_t                     o_lp_mode,
  output logic                         o_wake
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  seq_state_t                sq_ff;
  seq_state_t                nxt_sq;
  lp_mode_t                  lp_ff;
  logic [11:0]               pin_s1_ff;
  logic [11:0]               pin_s2_ff;
  logic [3:0]                act_prev_ff;
  logic [3:0]                act;
  logic [3:0]                edge_evt;
  logic                      keyon_evt;
  logic [`IAW_NUM_SRC-1:0]   req_ff;
  logic [`IAW_NUM_SRC-1:0]   set_evt;
  logic [`IAW_NUM_SRC-1:0]   clr_sw;
  logic [`IAW_NUM_SRC-1:0]   clr_acc;
  logic [`IAW_NUM_SRC-1:0]   masked;
  logic [`IAW_NUM_SRC-1:0]   elig;
  logic [`IAW_NUM_SRC-1:0]   wake_mask;
  logic [4:0]                elig_pick;
  logic [4:0]                masked_pick;
  logic                      dis_ff;
  logic                      brk_pend_ff;
  logic                      accept;
  logic                      brk_take;
  logic [3:0]                win_idx;
  logic [3:0]                vec_idx_ff;
  cpu_ctx_t                  saved_ctx_ff;
  logic [7:0]                stack_wdata_ff;
  cpu_ctx_t                  restore_ctx_ff;
  logic                      restore_valid_ff;
  logic                      wake_ff;
  logic                      wake_now;

  // Lowest slot wins; returns {found, index}
  function automatic logic [4:0] first_set(
    input logic [`IAW_NUM_SRC-1:0] v
  );
    first_set = 5'h00;
    for (int k = `IAW_NUM_SRC - 1; k >= 0; k--)
    begin
      if (v[k])
        first_set = {1'b1, 4'(k)};
    end
  endfunction : first_set

  // ****************************************************************
  // Pin synchronisers and edge detection
  // ****************************************************************
  // Two flops per pin; edge logic reads only the second stage.
  // Reset to the idle-high pin level so no false falling edge follows reset.
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      pin_s1_ff <= 12'hFFF;
      pin_s2_ff <= 12'hFFF;
    end
    else
    begin
      pin_s1_ff <= {i_keyscan_port, i_counter_pin_b, i_counter_pin_a,
                    i_external_edge_pin_b, i_external_edge_pin_a};
      pin_s2_ff <= pin_s1_ff;
    end
  end

  // Polarity 0 picks the falling edge. Flipping the polarity flips the
  // active level, so a change can itself look like an edge.
  assign act      = pin_s2_ff[3:0] ^ ~i_edge_pol;
  // No port-mode gating: detection runs whatever the pin is used for
  assign edge_evt = act & ~act_prev_ff;

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      act_prev_ff <= 4'h0;
    else
      act_prev_ff <= act;
  end

  // Any low key line in stop or wait; a low key at entry fires at once
  assign keyon_evt = i_keyon_sel && !(&pin_s2_ff[11:4]) &&
                     (lp_ff != LP_RUN);

  // ****************************************************************
  // Request bits
  // ****************************************************************
  // Key-on shares the request slot of edge pin b
  assign set_evt = {i_periph_event, edge_evt[3:2],
                    (i_keyon_sel ? keyon_evt : edge_evt[1]),
                    edge_evt[0]};
  // Written 0 clears, written 1 leaves the bit alone
  assign clr_sw  = i_req_wr ? ~i_req_wr_data : '0;

  // A new event in the same cycle as a clear survives the clear
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      req_ff <= '0;
    else
      req_ff <= (req_ff & ~clr_sw & ~clr_acc) | set_evt;
  end

  assign o_req_bits = req_ff;

  // ****************************************************************
  // Gating and fixed priority
  // ****************************************************************
  assign masked      = req_ff & i_enable;
  assign elig        = masked & {`IAW_NUM_SRC{~dis_ff}};
  assign elig_pick   = first_set(elig);
  assign masked_pick = first_set(masked);

  // Taken only between instructions and never on a return
  assign accept   = (sq_ff == SQ_IDLE) && i_instr_done && !i_rti &&
                    (brk_pend_ff || elig_pick[4]);
  assign brk_take = accept && brk_pend_ff;

  // Break with the flag set borrows the best pending enabled vector
  always_comb
  begin
    if (brk_take && dis_ff && masked_pick[4])
      win_idx = masked_pick[3:0];
    else if (brk_take)
      win_idx = `IAW_VEC_BRK;
    else
      win_idx = elig_pick[3:0];
  end

  // Only the winner is cleared; losers keep their request set
  always_comb
  begin
    clr_acc = '0;
    if (accept && !brk_take)
      clr_acc[win_idx] = 1'b1;
  end

  // ****************************************************************
  // Break pending and disable flag
  // ****************************************************************
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      brk_pend_ff <= 1'b0;
    else if (i_brk)
      brk_pend_ff <= 1'b1;
    else if (brk_take)
      brk_pend_ff <= 1'b0;
  end

  // Hardware set on branch wins over a software clear
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      dis_ff <= `IAW_RST_DISABLE;
    else if (sq_ff == SQ_VEC_HI)
      dis_ff <= 1'b1;
    else if (sq_ff == SQ_POP_PS)
      dis_ff <= i_stack_rdata[`IAW_PS_I_BIT];
    else if (i_sei)
      dis_ff <= 1'b1;
    else if (i_cli)
      dis_ff <= 1'b0;
  end

  assign o_int_disable = dis_ff;

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_comb
  begin
    case (sq_ff)
      SQ_IDLE:
      begin
        if (i_rti && i_instr_done)
          nxt_sq = SQ_POP_PS;
        else if (accept)
          nxt_sq = SQ_POST;
        else
          nxt_sq = SQ_IDLE;
      end
      SQ_POST:     nxt_sq = SQ_PUSH_PCH;
      SQ_PUSH_PCH: nxt_sq = SQ_PUSH_PCL;
      SQ_PUSH_PCL: nxt_sq = SQ_PUSH_PS;
      SQ_PUSH_PS:  nxt_sq = SQ_VEC_LO;
      SQ_VEC_LO:   nxt_sq = SQ_VEC_HI;
      SQ_POP_PS:   nxt_sq = SQ_POP_PCL;
      SQ_POP_PCL:  nxt_sq = SQ_POP_PCH;
      default:     nxt_sq = SQ_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      sq_ff <= SQ_IDLE;
    else
      sq_ff <= nxt_sq;
  end

  // Snapshot of the context at acceptance; break skips one byte
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      saved_ctx_ff <= '0;
      vec_idx_ff   <= 4'h0;
    end
    else if (accept)
    begin
      saved_ctx_ff.pc <= brk_take ? i_ctx.pc + `IAW_BRK_PC_STEP
                                  : i_ctx.pc;
      saved_ctx_ff.ps <= i_ctx.ps;
      saved_ctx_ff.ps[`IAW_PS_I_BIT] <= dis_ff;
      saved_ctx_ff.ps[`IAW_PS_B_BIT] <= brk_take;
      vec_idx_ff      <= win_idx;
    end
  end

  // Push data is staged one state ahead of each push
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      stack_wdata_ff <= 8'h00;
    else
    begin
      case (sq_ff)
        SQ_POST:     stack_wdata_ff <= saved_ctx_ff.pc[15:8];
        SQ_PUSH_PCH: stack_wdata_ff <= saved_ctx_ff.pc[7:0];
        SQ_PUSH_PCL: stack_wdata_ff <= saved_ctx_ff.ps;
        default:     stack_wdata_ff <= stack_wdata_ff;
      endcase
    end
  end

  // Pops arrive status first, then low and high counter bytes
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      restore_ctx_ff   <= '0;
      restore_valid_ff <= 1'b0;
    end
    else
    begin
      restore_valid_ff <= (sq_ff == SQ_POP_PCH);
      case (sq_ff)
        SQ_POP_PS:  restore_ctx_ff.ps       <= i_stack_rdata;
        SQ_POP_PCL: restore_ctx_ff.pc[7:0]  <= i_stack_rdata;
        SQ_POP_PCH: restore_ctx_ff.pc[15:8] <= i_stack_rdata;
        default:    restore_ctx_ff          <= restore_ctx_ff;
      endcase
    end
  end

  // Handshake strobes except o_restore_valid are decoded straight from the state
  assign o_busy          = (sq_ff != SQ_IDLE);
  assign o_stack_push    = (sq_ff == SQ_PUSH_PCH) || (sq_ff == SQ_PUSH_PCL) ||
                           (sq_ff == SQ_PUSH_PS);
  assign o_stack_pop     = (sq_ff == SQ_POP_PS) || (sq_ff == SQ_POP_PCL) ||
                           (sq_ff == SQ_POP_PCH);
  assign o_stack_wdata   = stack_wdata_ff;
  assign o_vec.fetch     = (sq_ff == SQ_VEC_LO) || (sq_ff == SQ_VEC_HI);
  assign o_vec.high_byte = (sq_ff == SQ_VEC_HI);
  assign o_vec.index     = vec_idx_ff;
  assign o_branch        = (sq_ff == SQ_VEC_HI);
  assign o_restore_valid = restore_valid_ff;
  assign o_restore_ctx   = restore_ctx_ff;

  // ****************************************************************
  // Stop and wait modes
  // ****************************************************************
  // Timer 1, timer 2 and converter are absent from the stop set
  always_comb
  begin
    wake_mask = `IAW_STOP_WAKE_FIXED;
    wake_mask[`IAW_SRC_TIMER_X] = i_timer_x_event_mode;
    wake_mask[`IAW_SRC_TIMER_Y] = i_timer_y_event_mode;
    if (i_serial_ext_clk)
      wake_mask = wake_mask | `IAW_STOP_WAKE_SERIAL;
    if (lp_ff == LP_WAIT)
      wake_mask = '1;
  end

  // Wake ignores the disable flag so a masked core still resumes
  assign wake_now = (lp_ff != LP_RUN) && |(masked & wake_mask);

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      lp_ff   <= LP_RUN;
      wake_ff <= 1'b0;
    end
    else
    begin
      wake_ff <= wake_now;
      if (wake_now)
        lp_ff <= LP_RUN;
      else if (i_stop_enter)
        lp_ff <= LP_STOP;
      else if (i_wait_enter)
        lp_ff <= LP_WAIT;
    end
  end

  assign o_lp_mode = lp_ff;
  assign o_wake    = wake_ff;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_push_ctx;
    o_stack_push && o_stack_wdata == saved_ctx_ff.pc[15:8] ##1
    o_stack_push && o_stack_wdata == saved_ctx_ff.pc[7:0]  ##1
    o_stack_push && o_stack_wdata == saved_ctx_ff.ps;
  endsequence

  sequence s_vector;
    o_vec.fetch && !o_vec.high_byte && !o_branch ##1
    o_vec.fetch && o_vec.high_byte && o_branch;
  endsequence

  sequence s_pop_ctx;
    o_stack_pop ##1 o_stack_pop ##1 o_stack_pop ##1 o_restore_valid;
  endsequence

  a_accept_flow: assert property (
    accept |=> !o_stack_push ##1 s_push_ctx ##1 s_vector ##1 o_int_disable)
    else $error("acceptance sequence out of order");

  a_return_order: assert property (
    (sq_ff == SQ_IDLE && i_rti && i_instr_done) |=> s_pop_ctx)
    else $error("return pops out of order");

  a_gate_accept: assert property (
    (accept && !brk_take) |->
      (req_ff[win_idx] && i_enable[win_idx] && !dis_ff))
    else $error("source accepted while gated");

  a_fixed_priority: assert property (
    (accept && !brk_take) |->
      ((elig & ((12'h001 << win_idx) - 12'h001)) == '0))
    else $error("lower priority source taken first");

  a_accept_clears: assert property (
    (accept && !brk_take && !set_evt[win_idx]) |=>
      (!req_ff[$past(win_idx)] &&
       ((req_ff & $past(elig & ~clr_acc & ~clr_sw)) ==
        $past(elig & ~clr_acc & ~clr_sw))))
    else $error("request bits wrong after acceptance");

  a_sw_no_set: assert property (
    ((req_ff & ~$past(req_ff)) & ~$past(set_evt)) == '0)
    else $error("request bit set without an event");

  a_brk_context: assert property (
    brk_take |=>
      (saved_ctx_ff.pc == $past(i_ctx.pc) + `IAW_BRK_PC_STEP) &&
      saved_ctx_ff.ps[`IAW_PS_B_BIT] && sq_ff == SQ_POST)
    else $error("break context wrong");

  a_brk_vector: assert property (
    (brk_take && dis_ff && masked_pick[4]) |=> ##5
      (o_vec.index == $past(masked_pick[3:0], 6) && o_branch))
    else $error("break vector not highest pending source");

  a_stop_wake: assert property (
    (lp_ff == LP_STOP && !wake_now) |->
      ((masked & (`IAW_STOP_WAKE_FIXED |
        (12'(i_timer_x_event_mode) << `IAW_SRC_TIMER_X) |
        (12'(i_timer_y_event_mode) << `IAW_SRC_TIMER_Y) |
        (i_serial_ext_clk ? `IAW_STOP_WAKE_SERIAL : 12'h000))) == '0))
    else $error("allowed stop wake source ignored");

  a_keyon_run: assert property (
    (lp_ff == LP_RUN && i_keyon_sel) |-> !set_evt[`IAW_SRC_EXT_B])
    else $error("key-on active in run mode");

endmodule : interrupt_accept_and_wakeup_control

`default_nettype wire

// ### bench/stack_partner_model.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Core stack behind the sequencer's push and pop strobes
// ****************************************************************
module stack_partner_model (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // Stack strobes from the block
  input  wire logic        i_push,
  input  wire logic        i_pop,
  input  wire logic [7:0]  i_wdata,
  // Pop data, and the last three pushed bytes with the oldest on top
  output logic [7:0]       o_rdata,
  output logic [23:0]      o_pushed
);
  logic [7:0] mem_ff [0:15];
  logic [3:0] sp_ff;
  logic [7:0] top;

  // Last in, first out, so a return sees status, PC low, PC high
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sp_ff    <= 4'h0;
      o_pushed <= 24'h00_0000;
    end
    else
    begin
      if (i_push)
      begin
        mem_ff[sp_ff] <= i_wdata;
        o_pushed      <= {o_pushed[15:0], i_wdata};
      end
      sp_ff <= sp_ff + 4'(i_push) - 4'(i_pop);
    end
  end

  // Off a pop the bus shows no stale byte, so a late sample cannot pass
  assign top     = mem_ff[sp_ff - 4'h1];
  assign o_rdata = i_pop ? top : ~top;

endmodule : stack_partner_model

`default_nettype wire

// ### bench/interrupt_accept_and_wakeup_control_test.sv
`timescale 1ns/1ps
`default_nettype none

`include "iaw_defs.svh"

module interrupt_accept_and_wakeup_control_test
  import iaw_pkg::*;
;
  // ****************************************************************
  // Stimulus, outputs and bookkeeping
  // ****************************************************************
  localparam logic [6:0] DN = 7'h40, BK = 7'h20, RT = 7'h10, SE = 7'h08;
  localparam logic [6:0] CL = 7'h04, SP = 7'h02, WT = 7'h01;
  logic        i_clk = 1'b0, i_rst_n = 1'b0;
  logic        pa = 1'b1, ks_sel = 1'b0, txm = 1'b0, wr = 1'b0, sck = 1'b0;
  logic [3:0]  pol = 4'h0;
  logic [6:0]  ctl = 7'h00;
  logic [7:0]  ks = 8'hFF, pe = 8'h00, rdata, wdata;
  logic [11:0] en = 12'h000, wd = 12'h000, req;
  logic [23:0] pushed;
  cpu_ctx_t    ctx = 24'h00_0000, rctx;
  logic        busy, push, pop, br, rv, dis, wake;
  vec_req_t    vec;
  lp_mode_t    lp;
  int          n_errors = 0, num_checks = 0;

  // Core clock, 5 ns period
  always #2.5 i_clk = ~i_clk;

  interrupt_accept_and_wakeup_control dut_u (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_external_edge_pin_a(pa),
    .i_external_edge_pin_b(1'b1), .i_counter_pin_a(1'b1),
    .i_counter_pin_b(1'b1), .i_keyscan_port(ks), .i_edge_pol(pol),
    .i_keyon_sel(ks_sel), .i_enable(en), .i_timer_x_event_mode(txm),
    .i_timer_y_event_mode(txm), .i_serial_ext_clk(sck),
    .i_periph_event(pe), .i_req_wr(wr), .i_req_wr_data(wd),
    .o_req_bits(req), .i_instr_done(ctl[6]), .i_brk(ctl[5]),
    .i_rti(ctl[4]), .i_sei(ctl[3]), .i_cli(ctl[2]),
    .i_stop_enter(ctl[1]), .i_wait_enter(ctl[0]), .i_ctx(ctx),
    .i_stack_rdata(rdata), .o_busy(busy), .o_stack_push(push),
    .o_stack_pop(pop), .o_stack_wdata(wdata), .o_vec(vec),
    .o_branch(br), .o_restore_valid(rv), .o_restore_ctx(rctx),
    .o_int_disable(dis), .o_lp_mode(lp), .o_wake(wake));

  stack_partner_model stack_u (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_push(push), .i_pop(pop),
    .i_wdata(wdata), .o_rdata(rdata), .o_pushed(pushed));

  // ****************************************************************
  // Access tasks
  // ****************************************************************
  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask : cyc

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e)
    begin
      n_errors++;
      $display("FAIL %0t seen %0h expected %0h", $time, s, e);
    end
  endtask : chk

  // Sequencer strobes; a quiet cycle after each avoids double drives
  task automatic pulse(input logic [6:0] v);
    ctl = v;
    cyc(1);
    ctl = 7'h00;
    cyc(1);
  endtask : pulse

  task automatic ev(input logic [7:0] v);
    pe = v;
    cyc(1);
    pe = 8'h00;
    cyc(1);
  endtask : ev

  // Zeros clear request bits, ones leave them alone
  task automatic wreq(input logic [11:0] d);
    wd = d;
    wr = 1'b1;
    cyc(1);
    wr = 1'b0;
    cyc(2);
  endtask : wreq

  // One acceptance: vector slot at the branch, pushed bytes, flag after
  task automatic take(input logic [6:0] how, input logic [15:0] pc,
                      input logic [3:0] idx, input logic [7:0] ps);
    ctx.pc = pc;
    pulse(how);
    pulse(DN);
    cyc(4);
    chk(32'(br), 32'h1);
    chk(32'(vec), {26'h0, 2'b11, idx});
    cyc(2);
    if (how == BK)
      pc = pc + 16'h0002;
    chk(32'(pushed), {8'h00, pc, ps});
    chk(32'(dis), 32'h1);
  endtask : take

  task automatic end_of_test();
    if (n_errors == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  // Watchdog, far beyond the hundred or so cycles the tests need
  initial
  begin
    #20000;
    n_errors++;
    end_of_test();
  end

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial
  begin
    cyc(4);
    i_rst_n = 1'b1;
    cyc(2);
    chk(32'(dis), 32'h1);
    chk(32'(lp), 32'(LP_RUN));
    ev(8'h0A);
    wreq(12'hFFF);
    chk(32'(req), 32'h0A0);
    en = 12'h0A0;
    pulse(DN);
    chk(32'(busy), 32'h0);
    pulse(CL);
    en = 12'h000;
    pulse(DN);
    chk(32'(busy), 32'h0);
    en = 12'h0A0;
    take(7'h00, 16'h1234, 4'h5, 8'h00);
    chk(32'(req), 32'h080);
    pulse(DN | RT);
    cyc(2);
    chk(32'(rv), 32'h1);
    chk(32'(rctx), 32'h12_3400);
    chk(32'(dis), 32'h0);
    pulse(SE);
    take(BK, 16'h2000, 4'h7, 8'h14);
    chk(32'(req), 32'h080);
    en = 12'h000;
    take(BK, 16'h00FE, 4'hC, 8'h14);
    // Stop: timer 1 and timer X outside event count mode must not wake
    wreq(12'h000);
    chk(32'(req), 32'h000);
    en = 12'h1F2;
    pulse(SP);
    chk(32'(lp), 32'(LP_STOP));
    ev(8'h07);
    cyc(2);
    chk(32'(lp), 32'(LP_STOP));
    txm = 1'b1;
    cyc(1);
    chk(32'(wake), 32'h1);
    cyc(1);
    chk(32'(lp), 32'(LP_RUN));
    wreq(12'h000);
    pulse(WT);
    chk(32'(lp), 32'(LP_WAIT));
    ev(8'h04);
    chk(32'(wake), 32'h1);
    cyc(1);
    chk(32'(lp), 32'(LP_RUN));
    // Stop: serial receive wakes only with the external serial clock
    wreq(12'h000);
    pulse(SP);
    ev(8'h10);
    cyc(2);
    chk(32'(lp), 32'(LP_STOP));
    sck = 1'b1;
    cyc(2);
    chk(32'(lp), 32'(LP_RUN));
    // Key lines low in run mode give nothing; in stop they wake
    wreq(12'h000);
    ks_sel = 1'b1;
    ks = 8'hFE;
    cyc(6);
    chk(32'(req), 32'h000);
    ks = 8'hFF;
    cyc(4);
    pulse(SP);
    ks = 8'hEF;
    cyc(6);
    chk(32'(lp), 32'(LP_RUN));
    chk(32'(req), 32'h002);
    pa = 1'b0;
    cyc(5);
    chk(32'(req[0]), 32'h1);
    end_of_test();
  end

endmodule : interrupt_accept_and_wakeup_control_test

`default_nettype wire
